// ### logic/periodic_timer_pkg.sv
// Shared constants for the periodic timer unit
package periodic_timer_pkg;
  localparam int CNT_W = 10;
  localparam int BUS_AW = 5;
  // Register byte addresses
  localparam logic [4:0] ADDR_CTRL_ZERO = 5'h00;
  localparam logic [4:0] ADDR_CTRL_ONE = 5'h04;
  localparam logic [4:0] ADDR_CNT_LO = 5'h08;
  localparam logic [4:0] ADDR_CNT_HI = 5'h0C;
  localparam logic [4:0] ADDR_CMPA_LO = 5'h10;
  localparam logic [4:0] ADDR_CMPA_HI = 5'h14;
  localparam logic [4:0] ADDR_CMPA_SET = 5'h18;
  // Control zero fields
  localparam int PAUSE_BIT = 7;
  localparam int ENABLE_BIT = 3;
  // Control one fields
  localparam int MODE_HI_BIT = 7;
  localparam int MODE_LO_BIT = 6;
  localparam int PINFN_HI_BIT = 5;
  localparam int PINFN_LO_BIT = 4;
  localparam int OUT_LEVEL_BIT = 3;
  localparam int OUT_INVERT_BIT = 2;
  localparam int CAP_SRC_BIT = 1;
  localparam int CLR_SEL_BIT = 0;
  // Reset values
  localparam logic [7:0] CTRL_ZERO_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [9:0] CMPA_RST = 10'h000;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // Operating modes from the two mode bits
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAP = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // Pin function codes
  localparam logic [1:0] PINFN_0 = 2'h0;
  localparam logic [1:0] PINFN_1 = 2'h1;
  localparam logic [1:0] PINFN_2 = 2'h2;
  localparam logic [1:0] PINFN_3 = 2'h3;
  typedef enum logic [1:0] {BUS_IDLE, BUS_DONE} bus_state_type;
endpackage

// ### logic/timer_core_if.sv
// Signals between the control block and the counter core
`timescale 1ns/10ps
`default_nettype none
interface timer_core_if;
  import periodic_timer_pkg::*;
  logic tick;
  logic restart;
  logic clear_now;
  logic [CNT_W-1:0] compare_a;
  logic [CNT_W-1:0] period;
  logic [CNT_W-1:0] count;
  logic eq_a;
  logic eq_p;
  modport ctrl (output tick, restart, clear_now, compare_a, period,
    input count, eq_a, eq_p);
  modport core (input tick, restart, clear_now, compare_a, period,
    output count, eq_a, eq_p);
endinterface
`default_nettype wire

// ### logic/timer_counter_core.sv
// Ten-bit up counter with its two comparators
`timescale 1ns/10ps
`default_nettype none
module timer_counter_core
  import periodic_timer_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  timer_core_if.core cif // Link to control block
);
  logic [CNT_W-1:0] count_r;

  // Restart wins over counting; wrap past all ones is the overflow clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_r <= CNT_RST;
    end else if (cif.restart) begin
      count_r <= CNT_RST;
    end else if (cif.tick) begin
      if (cif.clear_now) begin
        count_r <= CNT_RST;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  assign cif.count = count_r;
  assign cif.eq_a = (count_r == cif.compare_a);
  // A zero period never matches, leaving overflow as the clear
  assign cif.eq_p = (cif.period != CNT_RST) && (count_r == cif.period);
endmodule
`default_nettype wire

// ### logic/periodic_timer_unit.sv
// Periodic timer unit: registers, modes, output pin and capture
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_unit
  import periodic_timer_pkg::*;
(
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst, // Async reset, active high
  input wire logic [BUS_AW-1:0] address, // Avalon byte address
  input wire logic read, // Avalon read request
  input wire logic write, // Avalon write request
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon stall
  input wire logic [CNT_W-1:0] period_compare_value, // Comparator P value
  input wire logic external_clock_input_pin, // Capture / trigger pin
  output logic timer_output_pin, // Output pin level
  output logic timer_output_enable, // High while pin driven
  output logic [CNT_W-1:0] compare_a_value // Comparator A value
);

  function automatic logic [7:0] low_byte(input logic [CNT_W-1:0] v);
    low_byte = v[7:0];
  endfunction

  function automatic logic [7:0] high_byte(input logic [CNT_W-1:0] v);
    high_byte = {6'h00, v[CNT_W-1:8]};
  endfunction

  timer_core_if cif ();

  timer_counter_core u_core (
    .clk(clk),
    .rst(rst),
    .cif(cif)
  );

  // Register state
  logic pause_r;
  logic enable_r;
  logic enable_d_r;
  logic [7:0] ctrl_one_r;
  logic [CNT_W-1:0] compare_a_r;
  bus_state_type bus_state_r;
  logic [31:0] readdata_r;

  // Pin synchroniser
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;
  logic pin_level_r;

  // Output state
  logic level_r;
  logic pin_r;
  logic pin_oe_r;

  // Decoded fields
  logic [1:0] mode;
  logic [1:0] pin_fn;
  logic out_level;
  logic out_invert;
  logic cap_src;
  logic clr_sel;
  logic single_pulse;
  logic cmp_like;

  // Events
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic enable_rise;
  logic enable_fall;
  logic tick;
  logic match_a;
  logic match_p;
  logic clear_now;
  logic pin_rise;
  logic pin_fall;
  logic capture_now;
  logic trigger_pin;
  logic single_end;
  logic pwm_active;
  logic pin_nxt;
  logic pin_oe_nxt;
  logic [31:0] readdata_nxt;

  assign mode = ctrl_one_r[MODE_HI_BIT:MODE_LO_BIT];
  assign pin_fn = ctrl_one_r[PINFN_HI_BIT:PINFN_LO_BIT];
  assign out_level = ctrl_one_r[OUT_LEVEL_BIT];
  assign out_invert = ctrl_one_r[OUT_INVERT_BIT];
  assign cap_src = ctrl_one_r[CAP_SRC_BIT];
  assign clr_sel = ctrl_one_r[CLR_SEL_BIT];
  assign single_pulse = (mode == MODE_PWM) && (pin_fn == PINFN_3);
  // Timer/counter counts exactly like compare match mode
  assign cmp_like = (mode == MODE_CMP) || (mode == MODE_TMR);

  // ---------------- Avalon slave ----------------
  // Every access stalls one cycle; read data come from a flop
  assign bus_req = read | write;
  assign bus_take = bus_req && (bus_state_r == BUS_DONE);
  assign wr_take = write && bus_take;
  assign waitrequest = bus_req && (bus_state_r != BUS_DONE);
  assign readdata = readdata_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_state_r <= BUS_IDLE;
    end else begin
      case (bus_state_r)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_state_r <= BUS_DONE;
          end
        end
        BUS_DONE: begin
          bus_state_r <= BUS_IDLE;
        end
        default: begin
          bus_state_r <= BUS_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    readdata_nxt = UNMAPPED_RD;
    case (address)
      ADDR_CTRL_ZERO: begin
        readdata_nxt[PAUSE_BIT] = pause_r;
        readdata_nxt[ENABLE_BIT] = enable_r;
      end
      ADDR_CTRL_ONE: begin
        readdata_nxt[7:0] = ctrl_one_r;
      end
      ADDR_CNT_LO: begin
        readdata_nxt[7:0] = low_byte(cif.count);
      end
      ADDR_CNT_HI: begin
        readdata_nxt[7:0] = high_byte(cif.count);
      end
      ADDR_CMPA_LO: begin
        readdata_nxt[7:0] = low_byte(compare_a_r);
      end
      ADDR_CMPA_HI: begin
        readdata_nxt[7:0] = high_byte(compare_a_r);
      end
      ADDR_CMPA_SET: begin
        readdata_nxt[CNT_W-1:0] = compare_a_r;
      end
      default: begin
        readdata_nxt = UNMAPPED_RD;
      end
    endcase
  end

  // Sampled in the stall cycle, stands through the accepting edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_r <= UNMAPPED_RD;
    end else if (read && (bus_state_r == BUS_IDLE)) begin
      readdata_r <= readdata_nxt;
    end
  end

  // ---------------- Control registers ----------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_one_r <= CTRL_ONE_RST;
    end else if (wr_take && (address == ADDR_CTRL_ONE)) begin
      ctrl_one_r <= writedata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pause_r <= CTRL_ZERO_RST[PAUSE_BIT];
    end else if (wr_take && (address == ADDR_CTRL_ZERO)) begin
      pause_r <= writedata[PAUSE_BIT];
    end
  end

  // Software write beats the hardware clear so a fresh trigger is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_r <= CTRL_ZERO_RST[ENABLE_BIT];
    end else if (wr_take && (address == ADDR_CTRL_ZERO)) begin
      enable_r <= writedata[ENABLE_BIT];
    end else if (single_pulse && trigger_pin && !enable_r) begin
      enable_r <= 1'b1;
    end else if (single_pulse && match_a) begin
      enable_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_d_r <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
    end
  end

  assign enable_rise = enable_r && !enable_d_r;
  assign enable_fall = !enable_r && enable_d_r;

  // ---------------- Pin synchroniser ----------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= external_clock_input_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Level changes only once the last two stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_level_r <= 1'b0;
    end else if (pin_s2_r == pin_s3_r) begin
      pin_level_r <= pin_s3_r;
    end
  end

  assign pin_rise = (pin_s2_r == pin_s3_r) && pin_s3_r && !pin_level_r;
  assign pin_fall = (pin_s2_r == pin_s3_r) && !pin_s3_r && pin_level_r;
  assign trigger_pin = pin_rise;

  // ---------------- Counter control ----------------
  // No tick in the restart cycle: the stale count must not match
  assign tick = enable_r && !pause_r && !enable_rise;
  assign cif.tick = tick;
  assign cif.restart = enable_rise;
  assign cif.period = period_compare_value;
  assign cif.compare_a = compare_a_r;

  // In compare modes a zero comparator A value never matches
  always_comb begin
    match_a = 1'b0;
    match_p = 1'b0;
    clear_now = 1'b0;
    if (cmp_like) begin
      match_a = tick && cif.eq_a && (compare_a_r != CMPA_RST);
      match_p = tick && cif.eq_p && !clr_sel;
      if (clr_sel) begin
        clear_now = match_a;
      end else begin
        clear_now = match_p;
      end
    end else begin
      // Clear select has no say here; period always clears
      match_a = tick && cif.eq_a;
      match_p = tick && cif.eq_p;
      clear_now = match_p;
    end
  end

  assign cif.clear_now = clear_now;

  // ---------------- Capture ----------------
  always_comb begin
    capture_now = 1'b0;
    if ((mode == MODE_CAP) && cap_src && enable_r) begin
      case (pin_fn)
        PINFN_0: capture_now = pin_rise;
        PINFN_1: capture_now = pin_fall;
        PINFN_2: capture_now = pin_rise || pin_fall;
        default: capture_now = 1'b0;
      endcase
    end
  end

  // Captured count is the only hardware path into comparator A
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compare_a_r <= CMPA_RST;
    end else if (capture_now) begin
      compare_a_r <= cif.count;
    end else if (wr_take && (address == ADDR_CMPA_SET)) begin
      compare_a_r <= writedata[CNT_W-1:0];
    end
  end

  assign compare_a_value = compare_a_r;

  // ---------------- Output level ----------------
  assign single_end = single_pulse && (match_a || enable_fall);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_r <= 1'b0;
    end else if (enable_rise && (mode == MODE_CMP || mode == MODE_PWM)) begin
      level_r <= out_level;
    end else if (single_end) begin
      level_r <= !out_level;
    end else if ((mode == MODE_CMP) && match_a) begin
      case (pin_fn)
        PINFN_1: level_r <= 1'b0;
        PINFN_2: level_r <= 1'b1;
        PINFN_3: level_r <= !level_r;
        default: level_r <= level_r;
      endcase
    end
  end

  // Duty above the period gives a steady active level
  assign pwm_active = (cif.count < compare_a_r);

  always_comb begin
    pin_nxt = 1'b0;
    pin_oe_nxt = 1'b0;
    case (mode)
      MODE_CMP: begin
        pin_nxt = level_r ^ out_invert;
        pin_oe_nxt = 1'b1;
      end
      MODE_PWM: begin
        pin_oe_nxt = 1'b1;
        case (pin_fn)
          PINFN_0: pin_nxt = !out_level;
          PINFN_1: pin_nxt = out_level;
          PINFN_2: pin_nxt = pwm_active ? out_level : !out_level;
          default: pin_nxt = level_r;
        endcase
        pin_nxt = pin_nxt ^ out_invert;
      end
      MODE_TMR: begin
        pin_nxt = 1'b0;
        pin_oe_nxt = 1'b0;
      end
      default: begin
        pin_nxt = 1'b0;
        pin_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign timer_output_pin = pin_r;
  assign timer_output_enable = pin_oe_r;

  // Counter bytes have no write path at all
  // is kept by the absence of any count load from the bus

endmodule
`default_nettype wire

// ### verif/periodic_timer_props.sv
// Port-level checker for the periodic timer unit
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_props
  import periodic_timer_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic [BUS_AW-1:0] address, // Bus address
  input wire logic read, // Bus read
  input wire logic write, // Bus write
  input wire logic [31:0] writedata, // Bus write data
  input wire logic [31:0] readdata, // Bus read data
  input wire logic waitrequest, // Bus stall
  input wire logic [CNT_W-1:0] period_compare_value, // Period value
  input wire logic external_clock_input_pin, // Trigger pin
  input wire logic timer_output_pin, // Output pin
  input wire logic timer_output_enable, // Pin drive enable
  input wire logic [CNT_W-1:0] compare_a_value // Comparator A value
);
  logic [7:0] ctl1_r;
  logic en_r;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_rd(a); read && !waitrequest && address == a; endsequence
  // Shadows of the control bits, landing with the accepted write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl1_r <= 8'h00;
    end else if (write && !waitrequest && address == ADDR_CTRL_ONE) begin
      ctl1_r <= writedata[7:0];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= 1'b0;
    end else if (write && !waitrequest && address == ADDR_CTRL_ZERO) begin
      en_r <= writedata[ENABLE_BIT];
    end
  end
  AST_WAIT_FIRST: assert property ((read || write) && !$past(read || write) |-> waitrequest)
    else $error("no wait state on new request");
  AST_ONE_WAIT: assert property (s_req |=> !waitrequest)
    else $error("more than one wait state");
  AST_PIN_IDLE: assert property (ctl1_r[6] && $past(ctl1_r[6]) |-> !timer_output_enable)
    else $error("pin driven in capture or timer mode");
  AST_EN_INIT: assert property ($rose(en_r) && ctl1_r[7:6] == MODE_CMP && $stable(ctl1_r)
    |-> ##[0:2] timer_output_pin == (ctl1_r[3] ^ ctl1_r[2])) else $error("initial level wrong");
  AST_CNT_HI: assert property (s_rd(ADDR_CNT_HI) |-> readdata[31:2] == 30'h0)
    else $error("count high byte upper bits set");
  AST_CMPA_LO: assert property (s_rd(ADDR_CMPA_LO)
    |-> readdata == {24'h0, $past(compare_a_value[7:0])}) else $error("compare A low wrong");
  AST_CMPA_HI: assert property (s_rd(ADDR_CMPA_HI)
    |-> readdata == {30'h0, $past(compare_a_value[9:8])}) else $error("compare A high wrong");
  AST_PWM_LEVEL: assert property (ctl1_r[7:5] == 3'h4 && $stable(ctl1_r)
    |-> timer_output_enable && timer_output_pin == (~ctl1_r[4] ^ ctl1_r[3] ^ ctl1_r[2]))
    else $error("forced pulse-width level wrong");
endmodule
bind periodic_timer_unit periodic_timer_props props_i (.clk(clk), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .period_compare_value(period_compare_value),
  .external_clock_input_pin(external_clock_input_pin), .timer_output_pin(timer_output_pin),
  .timer_output_enable(timer_output_enable), .compare_a_value(compare_a_value));
`default_nettype wire

// ### verif/timer_pin_model.sv
// Model of the trigger source wired to the timer's input pin
`timescale 1ns/10ps
`default_nettype none
module timer_pin_model (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset
  input wire logic fire, // Request one trigger pulse
  output logic ext_pin // Trigger pin into the timer
);
  logic [3:0] hold_r;
  // Long enough to pass the pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_r <= 4'h0;
    end else if (fire) begin
      hold_r <= 4'h8;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end
  assign ext_pin = (hold_r != 4'h0);
endmodule
`default_nettype wire

// ### verif/periodic_timer_unit_bench.sv
// Self-checking bench for the periodic timer unit
`timescale 1ns/10ps
`default_nettype none
module periodic_timer_unit_bench;
  import periodic_timer_pkg::*;
  logic clk, rst, read, write, ext_pin, pin, pin_oe, fire, waitrequest;
  logic [BUS_AW-1:0] address;
  logic [31:0] writedata, readdata, rv, lo;
  logic [CNT_W-1:0] period, cmpa;
  int fails, checks, cyc, cnt;
  logic [BUS_AW-1:0] raddr [6] = '{ADDR_CTRL_ONE, ADDR_CNT_LO, ADDR_CNT_HI, ADDR_CMPA_LO,
    ADDR_CMPA_HI, 5'h1C};
  logic [7:0] c1_t [4] = '{8'h01, 8'h00, 8'h00, 8'h81};
  int a_t [4] = '{5, 3, 3, 3};
  int p_t [4] = '{300, 7, 0, 0};
  int lo_t [4] = '{0, 0, 50, 50};
  int hi_t [4] = '{5, 7, 200, 200};
  logic [7:0] pc_t [9] = '{8'h08, 8'h00, 8'h0C, 8'h04, 8'hCC, 8'h98, 8'h88, 8'h94, 8'h4C};
  logic [1:0] pe_t [9] = '{2'h3, 2'h2, 2'h2, 2'h3, 2'h0, 2'h3, 2'h2, 2'h3, 2'h0};
  periodic_timer_unit uut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .period_compare_value(period), .external_clock_input_pin(ext_pin),
    .timer_output_pin(pin), .timer_output_enable(pin_oe), .compare_a_value(cmpa));
  timer_pin_model pins (.clk(clk), .rst(rst), .fire(fire), .ext_pin(ext_pin));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up;
    $display("Checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 900 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      $display("ERROR at %0t: timeout", $time);
      wrap_up();
    end
  end
  task automatic bus(input logic w, input logic [BUS_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~w;
    write <= w;
    // Request stands until a rising edge sees the stall low
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [BUS_AW-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  // Timer is stopped first so the enable write is a clean rise
  task automatic run(input logic [7:0] c1, input int a, input int p, input int n);
    bus(1'b1, ADDR_CTRL_ZERO, 32'h0);
    bus(1'b1, ADDR_CTRL_ONE, {24'h0, c1});
    bus(1'b1, ADDR_CMPA_SET, 32'(a));
    period <= 10'(p);
    bus(1'b1, ADDR_CTRL_ZERO, 32'h08);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    {rst, read, write, fire} = 4'hF;
    {read, write, fire} = 3'h0;
    address = 5'h00;
    writedata = 32'h0;
    period = 10'h000;
    cyc = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (raddr[i]) rchk(raddr[i], 32'h0);
    bus(1'b1, ADDR_CTRL_ONE, 32'hFF);
    rchk(ADDR_CTRL_ONE, 32'hFF);
    bus(1'b1, ADDR_CMPA_SET, 32'h2A5);
    rchk(ADDR_CMPA_LO, 32'hA5);
    rchk(ADDR_CMPA_HI, 32'h02);
    for (int i = 0; i < 4; i++) begin
      run(c1_t[i], a_t[i], p_t[i], 100);
      bus(1'b1, ADDR_CTRL_ZERO, 32'h88);
      bus(1'b0, ADDR_CNT_LO, 32'h0);
      lo = rv;
      bus(1'b1, ADDR_CNT_LO, ~lo);
      rchk(ADDR_CNT_LO, lo);
      bus(1'b0, ADDR_CNT_HI, 32'h0);
      cnt = int'({rv[1:0], lo[7:0]});
      chk({31'h0, cnt >= lo_t[i] && cnt <= hi_t[i]}, 32'h1);
    end
    for (int i = 0; i < 9; i++) begin
      run(pc_t[i], 500, 0, 4);
      chk({30'h0, pin_oe, pin}, {30'h0, pe_t[i]});
    end
    run(8'hB8, 30, 0, 10);
    chk({31'h0, pin}, 32'h1);
    repeat (50) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (12) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    run(8'h42, 0, 0, 40);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (20) @(posedge clk);
    chk({31'h0, cmpa >= 10'h01E && cmpa <= 10'h046}, 32'h1);
    rchk(ADDR_CMPA_LO, 32'h0000_002C);
    wrap_up();
  end
endmodule
`default_nettype wire
